// *** core/srch_params.svh ***
// Constants for the supply remote command handler.
// Assumes values in mV / mA and channels numbered from one.
`ifndef SRCH_PARAMS_SVH
`define SRCH_PARAMS_SVH

`define SRCH_NCHAN        4
`define SRCH_ADDR_DEFAULT 5'h05
`define SRCH_ADDR_MAX     5'h1e
`define SRCH_MIN_CURR     16'h0032
`define SRCH_MAX_VOLT     16'hd6d8
`define SRCH_MAX_CURR     16'h2710
`define SRCH_NDIGIT       5
`define SRCH_CONV_STEPS   5'h10
`define SRCH_ASCII_ZERO   8'h30

`define SRCH_OFF_CTRL     12'h000
`define SRCH_OFF_STATUS   12'h004
`define SRCH_OFF_PROT     12'h008

`define SRCH_ST_REMOTE    0
`define SRCH_ST_LOCKOUT   1
`define SRCH_ST_ERROR     2
`define SRCH_ST_ADDRESSED 3
`define SRCH_ST_BUFFULL   4
`define SRCH_CTRL_ERRCLR  8

`endif

// *** core/srch_pkg.sv ***
// Types shared by the supply remote command handler.
// Assumes srch_params.svh is on the include path.
package srch_pkg;

    typedef enum logic [3:0] {
        SRCH_OP_NONE,
        SRCH_OP_VSETPT,
        SRCH_OP_ISETPT,
        SRCH_OP_VMEAS,
        SRCH_OP_IMEAS,
        SRCH_OP_OUT,
        SRCH_OP_OVLEVEL,
        SRCH_OP_OCPEN,
        SRCH_OP_OVRST,
        SRCH_OP_OCRST
    } srch_op_t;

    // One decoded command: channel is 1..4, value in mV, mA or 0/1
    typedef struct packed {
        srch_op_t    op;
        logic [2:0]  chan;
        logic [15:0] value;
    } srch_cmd_t;

    typedef struct packed {
        logic [15:0] volt;
        logic [15:0] curr;
    } srch_pair_t;

endpackage

// *** core/srch_top.sv ***
// Remote command handler of a four-output supply, with AXI4-Lite registers.
// Assumes an external bus interface decodes commands and reports addressing.
// Function
// [RULE1] Bus address is five after factory reset.
// [RULE2] Addresses zero to thirty are accepted; others raise the error flag.
// [RULE3] Address is kept in non-volatile storage across power loss.
// [RULE4] Addressed indicator lights while addressed as talker or listener.
// [RULE5] Query answers go into an output buffer, not the display.
// [RULE6] Buffer holds until read as talker data or overwritten.
// [RULE7] Measure queries answer with the named channel's measured value.
// [RULE8] Voltage and current set values apply to the named channel.
// [RULE9] Output off forces zero volts and minimum current.
// [RULE10] Output on restores the stored voltage and current.
// [RULE11] Voltage above overvoltage level fires crowbar and disables output.
// [RULE12] With protection enabled, constant current mode switches channel off.
// [RULE13] Protection command argument one enables, zero disables, per channel.
// [RULE14] With protection disabled, constant current mode keeps running.
// [RULE15] In remote mode panel keys cannot change outputs.
// [RULE16] In remote mode the display still shows readings and settings.
// [RULE17] Local key returns to local unless lockout was received.
// [RULE18] Mode changes leave outputs untouched.
// [RULE19] Invalid commands are not executed and set the error flag.
// [RULE20] Answers are ASCII decimal digits ending with end-of-message.
`timescale 1ns/10ps
`include "srch_params.svh"

module srch_top
    import srch_pkg::*;
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite slave
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Bus interface state and decoded listener commands
    input  wire logic              bus_listen,
    input  wire logic              bus_talk,
    input  wire logic              bus_remote_en,
    input  wire logic              bus_lockout,
    input  wire logic              bus_cmd_valid,
    input  wire srch_cmd_t         bus_cmd,
    // Talker byte stream
    output logic [7:0]             talk_data,
    output logic                   talk_valid,
    output logic                   talk_eom,
    input  wire logic              talk_ready,
    // Front panel
    input  wire logic              return_to_local_key,
    input  wire logic              panel_cmd_valid,
    input  wire srch_cmd_t         panel_cmd,
    input  wire logic [1:0]        disp_sel,
    output srch_pair_t             disp_meas,
    output srch_pair_t             disp_set,
    output logic                   addressed_led,
    output logic                   remote_indicator,
    output logic                   error_led,
    // Non-volatile address store
    input  wire logic [4:0]        nv_addr,
    input  wire logic              nv_addr_ok,
    output logic                   nv_wr,
    output logic [4:0]             nv_wdata,
    // Analog front end, per channel
    input  wire srch_pair_t        meas [`SRCH_NCHAN],
    input  wire logic [3:0]        constant_current_mode,
    output srch_pair_t             prog [`SRCH_NCHAN],
    output logic [3:0]             crowbar
);

    typedef enum {S_IDLE, S_CONV} srch_conv_t;

    logic [4:0]  bus_addr_q;
    logic        boot_q;
    logic        remote_q, lockout_q, err_q;
    logic [3:0]  on_q, ov_q, oc_q, ocp_q;
    logic [15:0] voltage_setpoint_cmd_q [`SRCH_NCHAN];
    logic [15:0] current_setpoint_cmd_q [`SRCH_NCHAN];
    logic [15:0] ovl_q  [`SRCH_NCHAN];
    logic [7:0]  obuf_q [`SRCH_NDIGIT];
    logic        obuf_full_q;
    logic [2:0]  rd_idx_q;
    srch_conv_t  conv_st_q;
    logic [35:0] conv_q;
    logic [4:0]  conv_cnt_q;
    logic        bvalid_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic        nv_wr_q;

    // Remote wins the command source; panel only acts in local mode
    wire        panel_take = panel_cmd_valid & ~remote_q;                // see [RULE15]
    wire        cmd_valid  = bus_cmd_valid | panel_take;
    srch_cmd_t  cmd;
    assign cmd = bus_cmd_valid ? bus_cmd : panel_cmd;
    wire [1:0]  ch       = 2'(cmd.chan - 3'h1);
    wire        chan_ok  = (cmd.chan != 3'h0) && (cmd.chan <= 3'(`SRCH_NCHAN));
    wire        bool_ok  = cmd.value <= 16'h0001;
    wire        val_ok   = (cmd.op == SRCH_OP_VSETPT)  ? cmd.value <= `SRCH_MAX_VOLT :
                           (cmd.op == SRCH_OP_ISETPT)  ? cmd.value <= `SRCH_MAX_CURR :
                           (cmd.op == SRCH_OP_OVLEVEL) ? cmd.value <= `SRCH_MAX_VOLT :
                           (cmd.op == SRCH_OP_OUT)     ? bool_ok :
                           (cmd.op == SRCH_OP_OCPEN)   ? bool_ok :
                           (cmd.op != SRCH_OP_NONE);
    wire        cmd_bad  = cmd_valid & ~(chan_ok & val_ok);              // see [RULE19]
    wire        cmd_go   = cmd_valid & chan_ok & val_ok;
    wire        is_query = cmd.op == SRCH_OP_VMEAS || cmd.op == SRCH_OP_IMEAS;
    wire        query_go = cmd_go & is_query & bus_cmd_valid;            // see [RULE5]
    wire [15:0] query_val = (cmd.op == SRCH_OP_VMEAS) ? meas[ch].volt
                                                      : meas[ch].curr;  // see [RULE7]

    // AXI decode
    wire        wr_fire  = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    wire        rd_fire  = s_axi_arvalid & ~rvalid_q;
    wire        wr_ctrl  = wr_fire && s_axi_awaddr == `SRCH_OFF_CTRL;
    wire        wr_map   = wr_ctrl || s_axi_awaddr == `SRCH_OFF_STATUS
                           || s_axi_awaddr == `SRCH_OFF_PROT;
    wire        addr_wr  = wr_ctrl & s_axi_wstrb[0];
    wire        addr_ok  = s_axi_wdata[4:0] <= `SRCH_ADDR_MAX;           // see [RULE2]
    wire        err_clr  = wr_ctrl & s_axi_wstrb[1] & s_axi_wdata[`SRCH_CTRL_ERRCLR];
    wire        err_set  = cmd_bad | (addr_wr & ~addr_ok);
    wire [31:0] status_w = {8'h00, oc_q, ov_q, on_q, ocp_q, 3'h0, obuf_full_q,
                            addressed_led, err_q, lockout_q, remote_q};
    wire [31:0] rd_word  = (s_axi_araddr == `SRCH_OFF_CTRL)   ? {27'h0, bus_addr_q} :
                           (s_axi_araddr == `SRCH_OFF_STATUS) ? status_w :
                           (s_axi_araddr == `SRCH_OFF_PROT)   ? {28'h0, ocp_q} : 32'h0;
    wire        rd_map   = s_axi_araddr == `SRCH_OFF_CTRL || s_axi_araddr == `SRCH_OFF_STATUS
                           || s_axi_araddr == `SRCH_OFF_PROT;

    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = rd_fire;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= 2'h0;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_map ? 2'h0 : 2'h3;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q  <= 2'h0;
            rdata_q  <= 32'h0;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= rd_map ? 2'h0 : 2'h3;
            rdata_q  <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Address: default until the store is read one cycle after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_addr_q <= `SRCH_ADDR_DEFAULT;                            // see [RULE1]
            boot_q     <= 1'b1;
            nv_wr_q    <= 1'b0;
        end else begin
            boot_q  <= 1'b0;
            nv_wr_q <= addr_wr & addr_ok;
            if (boot_q && nv_addr_ok && nv_addr <= `SRCH_ADDR_MAX)
                bus_addr_q <= nv_addr;                                   // see [RULE3]
            else if (addr_wr && addr_ok)
                bus_addr_q <= s_axi_wdata[4:0];                          // see [RULE2]
        end
    end
    assign nv_wr    = nv_wr_q;                                           // see [RULE3]
    assign nv_wdata = bus_addr_q;

    // Error flag: a new fault in the clearing cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn)
            err_q <= 1'b0;
        else
            err_q <= err_set | (err_q & ~err_clr);                      // see [RULE19]
    end
    assign error_led = err_q;

    // Remote/local state; never touches the output registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remote_q  <= 1'b0;
            lockout_q <= 1'b0;
        end else if (!bus_remote_en) begin
            remote_q  <= 1'b0;
            lockout_q <= 1'b0;
        end else begin
            if (bus_lockout)
                lockout_q <= 1'b1;
            if (bus_listen || bus_lockout)
                remote_q <= 1'b1;
            else if (return_to_local_key && !lockout_q)
                remote_q <= 1'b0;                                        // see [RULE17]
        end
    end
    assign remote_indicator = remote_q;
    assign addressed_led    = bus_listen | bus_talk;                     // see [RULE4]

    // Per-channel settings and protection
    for (genvar c = 0; c < `SRCH_NCHAN; c++) begin : g_chan
        wire sel    = cmd_go && ch == 2'(c);
        wire active = on_q[c] & ~ov_q[c] & ~oc_q[c];
        wire ov_hit = active && meas[c].volt > ovl_q[c];
        wire oc_hit = active && ocp_q[c] && constant_current_mode[c];   // see [RULE14]

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                voltage_setpoint_cmd_q[c] <= 16'h0;
                current_setpoint_cmd_q[c] <= `SRCH_MIN_CURR;
                ovl_q[c]  <= `SRCH_MAX_VOLT;
                on_q[c]   <= 1'b1;
                ocp_q[c]  <= 1'b0;
            end else if (sel) begin
                if (cmd.op == SRCH_OP_VSETPT)
                    voltage_setpoint_cmd_q[c] <= cmd.value;                              // see [RULE8]
                if (cmd.op == SRCH_OP_ISETPT)
                    current_setpoint_cmd_q[c] <= cmd.value;                              // see [RULE8]
                if (cmd.op == SRCH_OP_OVLEVEL)
                    ovl_q[c] <= cmd.value;
                if (cmd.op == SRCH_OP_OUT)
                    on_q[c] <= cmd.value[0];                             // see [RULE9] [RULE10]
                if (cmd.op == SRCH_OP_OCPEN)
                    ocp_q[c] <= cmd.value[0];                            // see [RULE13]
            end
        end

        // Trips latch until their reset command; a trip beats the reset
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ov_q[c] <= 1'b0;
                oc_q[c] <= 1'b0;
            end else begin
                ov_q[c] <= ov_hit | (ov_q[c] & ~(sel && cmd.op == SRCH_OP_OVRST));
                oc_q[c] <= oc_hit | (oc_q[c] & ~(sel && cmd.op == SRCH_OP_OCRST));
            end
        end

        assign crowbar[c]   = ov_q[c];                                   // see [RULE11]
        assign prog[c].volt = active ? voltage_setpoint_cmd_q[c] : 16'h0;               // see [RULE9] [RULE12]
        assign prog[c].curr = active ? current_setpoint_cmd_q[c] : `SRCH_MIN_CURR;      // see [RULE10]
    end

    // Display keeps working in remote mode
    assign disp_meas      = meas[disp_sel];                              // see [RULE16]
    assign disp_set.volt  = voltage_setpoint_cmd_q[disp_sel];
    assign disp_set.curr  = current_setpoint_cmd_q[disp_sel];

    // Binary to BCD, one bit per cycle; small area over speed
    function automatic logic [35:0] srch_dabble(input logic [35:0] v);
        logic [35:0] t;
        t = v;
        for (int d = 0; d < `SRCH_NDIGIT; d++) begin
            if (t[16 + 4*d +: 4] >= 4'h5)
                t[16 + 4*d +: 4] = 4'(t[16 + 4*d +: 4] + 4'h3);
        end
        return {t[34:0], 1'b0};
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_st_q  <= S_IDLE;
            conv_q     <= 36'h0;
            conv_cnt_q <= 5'h0;
        end else if (query_go) begin
            conv_st_q  <= S_CONV;
            conv_q     <= {20'h0, query_val};
            conv_cnt_q <= 5'h0;
        end else begin
            unique case (conv_st_q)
                S_IDLE: conv_cnt_q <= 5'h0;
                S_CONV: begin
                    conv_q     <= srch_dabble(conv_q);
                    conv_cnt_q <= 5'(conv_cnt_q + 5'h1);
                    if (conv_cnt_q == `SRCH_CONV_STEPS - 5'h1)
                        conv_st_q <= S_IDLE;
                end
            endcase
        end
    end
    wire conv_done = conv_st_q == S_CONV && conv_cnt_q == `SRCH_CONV_STEPS - 5'h1;
    wire [35:0] conv_last = srch_dabble(conv_q);

    // Output buffer: ASCII digits, most significant first
    wire talk_take = talk_valid & talk_ready;
    wire last_byte = rd_idx_q == 3'(`SRCH_NDIGIT - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            obuf_full_q <= 1'b0;
            rd_idx_q    <= 3'h0;
            for (int d = 0; d < `SRCH_NDIGIT; d++)
                obuf_q[d] <= 8'h0;
        end else if (conv_done) begin
            obuf_full_q <= 1'b1;                                         // see [RULE6]
            rd_idx_q    <= 3'h0;
            for (int d = 0; d < `SRCH_NDIGIT; d++)
                obuf_q[d] <= `SRCH_ASCII_ZERO
                             | {4'h0, conv_last[16 + 4*(`SRCH_NDIGIT-1-d) +: 4]}; // see [RULE20]
        end else if (query_go) begin
            obuf_full_q <= 1'b0;
        end else if (talk_take) begin
            rd_idx_q <= last_byte ? 3'h0 : 3'(rd_idx_q + 3'h1);
            if (last_byte)
                obuf_full_q <= 1'b0;                                     // see [RULE6]
        end
    end
    assign talk_valid = obuf_full_q & bus_talk;
    assign talk_data  = obuf_q[rd_idx_q];
    assign talk_eom   = talk_valid & last_byte;                          // see [RULE20]

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_query_issued;
        query_go;
    endsequence
    sequence s_buffer_loaded;
        ##1 obuf_full_q;
    endsequence

    a_addr_range: assert property (bus_addr_q <= `SRCH_ADDR_MAX) // see [RULE2]
        else $error("address out of range");
    a_addr_boot: assert property (boot_q |=> bus_addr_q == (($past(nv_addr_ok) // see [RULE1]
        && $past(nv_addr) <= `SRCH_ADDR_MAX) ? $past(nv_addr) : `SRCH_ADDR_DEFAULT))
        else $error("boot address wrong");
    a_led_follows: assert property ((bus_listen || bus_talk) |-> addressed_led) // see [RULE4]
        else $error("indicator dark");
    a_query_buffer: assert property ( // see [RULE5]
        s_query_issued ##1 (!query_go)[*8] ##1 (!query_go)[*8] |-> s_buffer_loaded)
        else $error("query not buffered");
    a_buffer_held: assert property ((obuf_full_q && !bus_talk && !query_go) // see [RULE6]
        |=> obuf_full_q && $stable(obuf_q[0]))
        else $error("buffer lost");
    a_off_forces: assert property ((cmd_go && cmd.op == SRCH_OP_OUT && !cmd.value[0]) // see [RULE9]
        |=> prog[$past(ch)].volt == 16'h0 && prog[$past(ch)].curr == `SRCH_MIN_CURR)
        else $error("off not forced");
    a_ov_crowbar: assert property ((on_q[0] && !ov_q[0] && !oc_q[0] // see [RULE11]
        && meas[0].volt > ovl_q[0]) |=> crowbar[0] && prog[0].volt == 16'h0)
        else $error("no overvoltage trip");
    a_oc_trip: assert property ((on_q[0] && !ov_q[0] && !oc_q[0] && ocp_q[0] // see [RULE12]
        && constant_current_mode[0]) |=> oc_q[0] && prog[0].curr == `SRCH_MIN_CURR)
        else $error("no overcurrent trip");
    a_cc_runs: assert property ((!ocp_q[1] && !oc_q[1]) |=> !oc_q[1]) // see [RULE14]
        else $error("tripped unprotected");
    a_panel_locked: assert property ((remote_q && panel_cmd_valid && !bus_cmd_valid) // see [RULE15]
        |=> $stable(voltage_setpoint_cmd_q[0]) && $stable(on_q))
        else $error("panel acted in remote");
    a_lockout_holds: assert property ((remote_q && lockout_q && bus_remote_en) // see [RULE17]
        |=> remote_q)
        else $error("left remote under lockout");
    a_mode_keeps: assert property ($changed(remote_q) && !$past(cmd_go) // see [RULE18]
        |-> $stable(on_q) && $stable(voltage_setpoint_cmd_q[0]))
        else $error("mode change altered outputs");
    a_bad_flags: assert property (cmd_bad |=> err_q ##0 $stable(voltage_setpoint_cmd_q[0])) // see [RULE19]
        else $error("invalid command not flagged");

endmodule

// *** dv/srch_host_model.sv ***
// Host controller model: pulses decoded commands, reads the talker stream.
// Assumes the handler samples every line on the rising edge of aclk.
`timescale 1ns/10ps
module srch_host_model
    import srch_pkg::*;
(
    // Clock
    input  wire logic       aclk,
    // Bus lines and decoded commands
    output logic            bus_listen,
    output logic            bus_talk,
    output logic            bus_remote_en,
    output logic            bus_lockout,
    output logic            bus_cmd_valid,
    output srch_cmd_t       bus_cmd,
    // Talker stream
    input  wire logic [7:0] talk_data,
    input  wire logic       talk_valid,
    input  wire logic       talk_eom,
    output logic            talk_ready
);
    initial begin
        {bus_listen, bus_talk, bus_remote_en, bus_lockout} = 4'h0;
        {bus_cmd_valid, talk_ready} = 2'h0;
        bus_cmd = '0;
    end
    task automatic ren(input logic rm, input logic lo, input logic ls);
        @(posedge aclk);
        bus_remote_en <= rm;
        bus_lockout <= lo;
        bus_listen <= ls;
    endtask
    // Payload scrambled after the pulse, so a stale read shows up
    task automatic send(input srch_op_t op, input logic [2:0] ch, input logic [15:0] v);
        @(posedge aclk);
        bus_cmd <= {op, ch, v};
        bus_cmd_valid <= 1'b1;
        @(posedge aclk);
        bus_cmd_valid <= 1'b0;
        bus_cmd <= ~bus_cmd;
    endtask
    // Slow reader drops ready for one cycle after each byte
    task automatic take(input logic slow, output logic [39:0] txt, output logic [4:0] eom);
        int n;
        n = 0;
        txt = '0;
        eom = '0;
        @(posedge aclk);
        bus_talk <= 1'b1;
        talk_ready <= 1'b1;
        while (n < 5) begin
            @(posedge aclk);
            if (talk_valid === 1'b1 && talk_ready === 1'b1) begin
                txt = {txt[31:0], talk_data};
                eom = {eom[3:0], talk_eom};
                n++;
                talk_ready <= !slow && n < 5;
            end else
                talk_ready <= 1'b1;
        end
        bus_talk <= 1'b0;
    endtask
endmodule

// *** dv/tb_top.sv ***
// Bench for the supply remote command handler: row table, then hand tests.
// Assumes srch_params.svh on the include path and the host model beside it.
`timescale 1ns/10ps
`include "srch_params.svh"
module tb_top
    import srch_pkg::*;;
    typedef struct packed {
        srch_cmd_t  cmd;
        logic [1:0] idx;
        srch_pair_t exp;
    } srch_row_t;
    logic        aclk = 1'b0, aresetn = 1'b0, nv_addr_ok = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hf, constant_current_mode = 4'h0, crowbar;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r, disp_sel = 2'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_listen, bus_talk;
    logic        bus_remote_en, bus_lockout, bus_cmd_valid, talk_valid, talk_eom;
    logic        return_to_local_key = 1'b0, panel_cmd_valid = 1'b0, talk_ready;
    logic        addressed_led, remote_indicator, error_led, nv_wr;
    logic [7:0]  talk_data;
    logic [4:0]  nv_addr = 5'h09, nv_wdata, eom;
    logic [39:0] txt;
    srch_cmd_t   bus_cmd, panel_cmd = '0;
    srch_pair_t  disp_meas, disp_set, prog [`SRCH_NCHAN], meas [`SRCH_NCHAN] = '{default: '0};
    int          failures = 0, checks = 0, nv_cnt = 0;
    srch_row_t   rows [12] = '{
        {SRCH_OP_VSETPT, 3'h1, 16'h1388, 2'h0, 16'h1388, 16'h0032},
        {SRCH_OP_ISETPT, 3'h2, 16'h01c2, 2'h1, 16'h0000, 16'h01c2},
        {SRCH_OP_ISETPT, 3'h1, 16'h03e8, 2'h0, 16'h1388, 16'h03e8},
        {SRCH_OP_OUT,    3'h1, 16'h0000, 2'h0, 16'h0000, 16'h0032},
        {SRCH_OP_VSETPT, 3'h1, 16'h1770, 2'h0, 16'h0000, 16'h0032},
        {SRCH_OP_OUT,    3'h1, 16'h0001, 2'h0, 16'h1770, 16'h03e8},
        {SRCH_OP_VSETPT, 3'h1, 16'hd6d9, 2'h0, 16'h1770, 16'h03e8},
        {SRCH_OP_OUT,    3'h1, 16'h0002, 2'h0, 16'h1770, 16'h03e8},
        {SRCH_OP_ISETPT, 3'h5, 16'h0001, 2'h0, 16'h1770, 16'h03e8},
        {SRCH_OP_ISETPT, 3'h2, 16'h2711, 2'h1, 16'h0000, 16'h01c2},
        {SRCH_OP_VSETPT, 3'h4, 16'hd6d8, 2'h3, 16'hd6d8, 16'h0032},
        {SRCH_OP_VSETPT, 3'h3, 16'h0bb8, 2'h2, 16'h0bb8, 16'h0032}};

    srch_top srch_top_i (.*);
    srch_host_model host_i (.aclk, .bus_listen, .bus_talk, .bus_remote_en, .bus_lockout,
        .bus_cmd_valid, .bus_cmd, .talk_data, .talk_valid, .talk_eom, .talk_ready);

    always #50 aclk = ~aclk;
    always @(posedge aclk) if (nv_wr === 1'b1) nv_cnt++;

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic rst;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do @(posedge aclk); while ((s_axi_awready & s_axi_wready) !== 1'b1);
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic key;
        return_to_local_key <= 1'b1;
        @(posedge aclk);
        return_to_local_key <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    initial begin
        repeat (5000) @(posedge aclk);
        failures++;
        wrap_up();
    end
    initial begin
        rst();
        chk("addr", 40'h05, nv_wdata);
        foreach (rows[i]) begin
            host_i.send(rows[i].cmd.op, rows[i].cmd.chan, rows[i].cmd.value);
            @(posedge aclk);
            chk("prog", rows[i].exp, prog[rows[i].idx]);
        end
        chk("err", 40'h1, error_led);
        axw(12'h000, 32'h0000011e);
        repeat (2) @(posedge aclk);
        chk("nv_wdata", 40'h1e, nv_wdata);
        chk("nv_cnt", 40'h1, nv_cnt);
        axw(12'h000, 32'h0000001f);
        repeat (2) @(posedge aclk);
        chk("bad_addr", {8'h1e, 32'h1}, {nv_wdata, nv_cnt});
        axr(12'h004);
        chk("err_bit", 40'h1, d[2]);
        axw(12'h00c, 32'h0);
        chk("bresp", 40'h3, r);
        axr(12'h010);
        chk("rresp", 40'h3, {d, 6'h0, r});
        meas[0] <= {16'h1374, 16'h0078};
        meas[1] <= {16'h04d2, 16'h01c2};
        host_i.send(SRCH_OP_VMEAS, 3'h1, 16'h0);
        host_i.take(1'b0, txt, eom);
        chk("vmeas", 40'h3034393830, txt);
        chk("eom", 40'h01, eom);
        host_i.send(SRCH_OP_VMEAS, 3'h2, 16'h0);
        host_i.send(SRCH_OP_IMEAS, 3'h2, 16'h0);
        repeat (40) @(posedge aclk);
        host_i.take(1'b1, txt, eom);
        chk("imeas", {40'h3030343530, 5'h01}, {txt, eom});
        host_i.send(SRCH_OP_OCPEN, 3'h2, 16'h1);
        constant_current_mode <= 4'h6;
        repeat (3) @(posedge aclk);
        chk("ocp_trip", 40'h0032, prog[1]);
        chk("cc_run", {16'h0bb8, 16'h0032}, prog[2]);
        axr(12'h008);
        chk("ocp_on", 40'h2, d[3:0]);
        host_i.send(SRCH_OP_OCPEN, 3'h2, 16'h0);
        axr(12'h008);
        chk("ocp_off", 40'h0, d[3:0]);
        host_i.send(SRCH_OP_OVLEVEL, 3'h3, 16'h0dac);
        meas[2] <= {16'h0e10, 16'h0000};
        repeat (3) @(posedge aclk);
        chk("crowbar", {4'h4, 16'h0}, {crowbar, prog[2].volt});
        meas[2] <= '0;
        host_i.send(SRCH_OP_OVRST, 3'h3, 16'h0);
        host_i.send(SRCH_OP_OCRST, 3'h2, 16'h0);
        @(posedge aclk);
        chk("trips", {4'h0, 16'h0bb8, 32'h1c2}, {crowbar, prog[2].volt, prog[1]});
        host_i.ren(1'b1, 1'b0, 1'b1);
        repeat (2) @(posedge aclk);
        chk("addressed", 40'h3, {addressed_led, remote_indicator});
        host_i.ren(1'b1, 1'b0, 1'b0);
        panel_cmd <= {SRCH_OP_VSETPT, 3'h1, 16'h07d0};
        panel_cmd_valid <= 1'b1;
        @(posedge aclk);
        panel_cmd_valid <= 1'b0;
        disp_sel <= 2'h1;
        repeat (2) @(posedge aclk);
        chk("panel", {16'h1770, 16'h03e8}, prog[0]);
        chk("disp", {16'h04d2, 16'h01c2, 16'h0, 16'h01c2}, {disp_meas, disp_set});
        key();
        chk("local", {1'b0, 16'h1770, 16'h03e8}, {remote_indicator, prog[0]});
        host_i.ren(1'b1, 1'b1, 1'b1);
        host_i.ren(1'b1, 1'b1, 1'b0);
        key();
        chk("lockout", 40'h1, remote_indicator);
        host_i.ren(1'b0, 1'b0, 1'b0);
        repeat (2) @(posedge aclk);
        chk("ren_off", {1'b0, 16'h1770, 16'h03e8}, {remote_indicator, prog[0]});
        {nv_addr, nv_addr_ok} <= {5'h1e, 1'b1};
        rst();
        chk("nv_boot", 40'h1e, nv_wdata);
        wrap_up();
    end
endmodule
